// ===== hdl/clk_sel_regs.svh
// Register offsets, field positions, reset values and timing counts of the clock selector.
// Assumes a byte-addressed register port with one 32-bit word per register.
`ifndef CLK_SEL_REGS_SVH
`define CLK_SEL_REGS_SVH

`define CS_ADDR_W            8
`define CS_PLL_SEL_OFS       8'h00
`define CS_SYSCLK_SEL_OFS    8'h04
`define CS_OSC_CTRL_OFS      8'h08
`define CS_SYS_CTRL1_OFS     8'h0C

`define CS_PLL_USE_BIT       0
`define CS_SYSCLK_FLAG_BIT   0
`define CS_SYSCLK_SEL_BIT    1
`define CS_PLL_EN_BIT        0
`define CS_HI_OSC_EN_BIT     8
`define CS_LO_OSC_EN_BIT     9
`define CS_GEAR_LSB          0
`define CS_GEAR_MSB          2
`define CS_PERIPH_SRC_BIT    4
`define CS_PRESCALE_LSB      8
`define CS_PRESCALE_MSB      10

`define CS_OSC_CTRL_RST      32'h00000300
`define CS_SYS_CTRL1_RST     32'h00000000

`define CS_PLL_MULT          4
`define CS_PLL_HALF_SHIFT    3
`define CS_SYNC_STAGES       3

`endif

// ===== hdl/clk_sel_pkg.sv
// Types shared by the clock selector and its glitch-free multiplexer.
// Assumes clk_sel_regs.svh carries all numeric constants.
package clk_sel_pkg;

   typedef enum logic [2:0] {
      MUX_RUN      = 3'b001,
      MUX_OLD_LOW  = 3'b010,
      MUX_NEW_LOW  = 3'b100
   } mux_state_t;

   typedef logic [2:0] ratio_code_t;

endpackage : clk_sel_pkg

// ===== hdl/safe_clk_mux.sv
// Glitch-free two-input multiplexer for clock levels sampled on ref_clk.
// Assumes both inputs are already synchronous to ref_clk.
`timescale 1ns/10ps
module safe_clk_mux
   import clk_sel_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic reset,
   input  wire logic clk_a,
   input  wire logic clk_b,
   input  wire logic sel,
   output logic      clk_out,
   output logic      sel_active
);

   mux_state_t state_r;
   logic       cur_r;
   logic       tgt_r;
   logic       gate_r;
   logic       out_r;

   wire        old_clk = cur_r ? clk_b : clk_a;
   wire        new_clk = tgt_r ? clk_b : clk_a;

   ////////////////////////////////////////////////////////////////////////////
   // Gate off only while the old clock is low, reopen only while the new one
   // is low, so no shortened phase escapes. A stopped-high clock stalls this.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         state_r <= MUX_RUN;
         cur_r   <= 1'b0;
         tgt_r   <= 1'b0;
         gate_r  <= 1'b1;
      end else begin
         case (state_r)
            MUX_RUN: begin
               if (sel != cur_r) begin
                  tgt_r   <= sel;
                  state_r <= MUX_OLD_LOW;
               end
            end
            MUX_OLD_LOW: begin
               if (!old_clk) begin
                  gate_r  <= 1'b0;
                  state_r <= MUX_NEW_LOW;
               end
            end
            MUX_NEW_LOW: begin
               if (!new_clk) begin
                  cur_r   <= tgt_r;
                  gate_r  <= 1'b1;
                  state_r <= MUX_RUN;
               end
            end
            default: state_r <= MUX_RUN;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) out_r <= 1'b0;
      else       out_r <= gate_r & old_clk;
   end

   assign clk_out    = out_r;
   assign sel_active = cur_r;

endmodule : safe_clk_mux

// ===== hdl/pow2_clk_divider.sv
// Power-of-two divider for a clock level sampled on ref_clk.
// Assumes the ratio is not changed while downstream logic runs.
`timescale 1ns/10ps
module pow2_clk_divider
   import clk_sel_pkg::*;
#(
   parameter int CNT_W = 6
)(
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic        clk_in,
   input  wire ratio_code_t shift,
   output logic             clk_out
);

   logic             in_d_r;
   logic [CNT_W-1:0] cnt_r;
   logic             out_r;

   wire              in_rise = clk_in & ~in_d_r;
   wire              tap     = (shift == 3'h0) ? clk_in : cnt_r[3'(shift - 3'h1)];

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         in_d_r <= 1'b0;
         cnt_r  <= '0;
         out_r  <= 1'b0;
      end else begin
         in_d_r <= clk_in;
         if (in_rise) cnt_r <= cnt_r + 1'b1;
         out_r  <= tap;
      end
   end

   assign clk_out = out_r;

endmodule : pow2_clk_divider

// ===== hdl/pll_and_sysclk_select.sv
// High-speed source choice, x4 PLL, gear, prescaler and system clock selection.
// Assumes oscillator pins are asynchronous to ref_clk and much slower than it.
//
// Function
// - PLL use bit, bit 0, picks oscillator (0) or PLL clock (1); resets 0.
// - PLL clock runs at four times the high-speed oscillator frequency.
// - System select bit 1 picks high-speed (0) or low-speed (1); resets 0.
// - Read-only bit 0 shows the clock actually in use; resets 0.
// - The system clock changes some cycles after the write, never at once.
// - Status follows select when switching ends; software polls for equality.
// - Gear divides the high-speed clock by 1, 2, 4 or 8.
// - Prescaler divides the peripheral clock by 1, 2, 4, 8, 16 or 32.
// - Reset: oscillators on, PLL off, gear one, every selector at default.
// - After reset all clocks but the low-speed one equal the oscillator.
// - PLL stays off after reset until software sets its enable bit.
`timescale 1ns/10ps
`include "clk_sel_regs.svh"
module pll_and_sysclk_select
   import clk_sel_pkg::*;
#(
   parameter int PER_W = 12,
   parameter int DIV_W = 6
)(
   input  wire logic                  ref_clk,
   input  wire logic                  reset,
   input  wire logic [`CS_ADDR_W-1:0] reg_addr,
   input  wire logic [31:0]           reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic      [31:0]           reg_rdata,
   input  wire logic                  hi_osc_in,
   input  wire logic                  lo_osc_in,
   output logic                       hi_osc_enable,
   output logic                       lo_osc_enable,
   output logic                       pll_running,
   output logic                       high_speed_clock,
   output logic                       gear_clock,
   output logic                       prescaler_clock,
   output logic                       system_clock,
   output logic                       sysclk_status_flag
);

   ////////////////////////////////////////////////////////////////////////////
   // Register storage

   logic                  pll_use_bit_r;
   logic                  sysclk_sel_r;
   logic                  pll_en_r;
   logic                  hi_osc_en_r;
   logic                  lo_osc_en_r;
   ratio_code_t           gear_divide_field_r;
   logic                  periph_source_field_r;
   ratio_code_t           prescale_divide_field_r;
   logic [31:0]           rdata_r;

   // Reset values come from the register words so the two cannot drift apart
   localparam logic        PLL_EN_RST    = 1'((`CS_OSC_CTRL_RST >> `CS_PLL_EN_BIT) & 32'h1);
   localparam logic        HI_OSC_EN_RST = 1'((`CS_OSC_CTRL_RST >> `CS_HI_OSC_EN_BIT) & 32'h1);
   localparam logic        LO_OSC_EN_RST = 1'((`CS_OSC_CTRL_RST >> `CS_LO_OSC_EN_BIT) & 32'h1);
   localparam ratio_code_t GEAR_RST      = 3'((`CS_SYS_CTRL1_RST >> `CS_GEAR_LSB) & 32'h7);
   localparam logic        PSRC_RST      = 1'((`CS_SYS_CTRL1_RST >> `CS_PERIPH_SRC_BIT) & 32'h1);
   localparam ratio_code_t PRESCALE_RST  = 3'((`CS_SYS_CTRL1_RST >> `CS_PRESCALE_LSB) & 32'h7);

   ////////////////////////////////////////////////////////////////////////////
   // Address decode

   wire hit_pll_sel    = (reg_addr == `CS_PLL_SEL_OFS);
   wire hit_sysclk_sel = (reg_addr == `CS_SYSCLK_SEL_OFS);
   wire hit_osc_ctrl   = (reg_addr == `CS_OSC_CTRL_OFS);
   wire hit_sys_ctrl1  = (reg_addr == `CS_SYS_CTRL1_OFS);

   wire wr_pll_sel     = reg_wr & hit_pll_sel;
   wire wr_sysclk_sel  = reg_wr & hit_sysclk_sel;
   wire wr_osc_ctrl    = reg_wr & hit_osc_ctrl;
   wire wr_sys_ctrl1   = reg_wr & hit_sys_ctrl1;

   ////////////////////////////////////////////////////////////////////////////
   // Writable fields; only documented bits are stored, the rest are dropped

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         pll_use_bit_r <= 1'b0;
      end else if (wr_pll_sel) begin
         pll_use_bit_r <= reg_wdata[`CS_PLL_USE_BIT];
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         sysclk_sel_r <= 1'b0;
      end else if (wr_sysclk_sel) begin
         sysclk_sel_r <= reg_wdata[`CS_SYSCLK_SEL_BIT];
      end
   end

   // Oscillators come up running, the PLL stopped
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         pll_en_r    <= PLL_EN_RST;
         hi_osc_en_r <= HI_OSC_EN_RST;
         lo_osc_en_r <= LO_OSC_EN_RST;
      end else if (wr_osc_ctrl) begin
         pll_en_r    <= reg_wdata[`CS_PLL_EN_BIT];
         hi_osc_en_r <= reg_wdata[`CS_HI_OSC_EN_BIT];
         lo_osc_en_r <= reg_wdata[`CS_LO_OSC_EN_BIT];
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         gear_divide_field_r     <= GEAR_RST;
         periph_source_field_r   <= PSRC_RST;
         prescale_divide_field_r <= PRESCALE_RST;
      end else if (wr_sys_ctrl1) begin
         gear_divide_field_r     <= reg_wdata[`CS_GEAR_MSB:`CS_GEAR_LSB];
         periph_source_field_r   <= reg_wdata[`CS_PERIPH_SRC_BIT];
         prescale_divide_field_r <= reg_wdata[`CS_PRESCALE_MSB:`CS_PRESCALE_LSB];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Ratio decode; codes outside the table fall back to divide-by-one

   wire ratio_code_t gear_shift = (gear_divide_field_r > 3'h3) ? 3'h0
                                                               : gear_divide_field_r;
   wire ratio_code_t pre_shift  = (prescale_divide_field_r > 3'h5) ? 3'h0
                                                           : prescale_divide_field_r;

   ////////////////////////////////////////////////////////////////////////////
   // Oscillator pin synchronisers; a level is taken once stages two and three agree

   logic [`CS_SYNC_STAGES-1:0] hi_sync_r;
   logic [`CS_SYNC_STAGES-1:0] lo_sync_r;
   logic                       hi_osc_r;
   logic                       lo_osc_r;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         hi_sync_r <= '0;
         lo_sync_r <= '0;
      end else begin
         hi_sync_r <= {hi_sync_r[1:0], hi_osc_in};
         lo_sync_r <= {lo_sync_r[1:0], lo_osc_in};
      end
   end

   wire hi_agree = (hi_sync_r[1] == hi_sync_r[2]);
   wire lo_agree = (lo_sync_r[1] == lo_sync_r[2]);

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         hi_osc_r <= 1'b0;
         lo_osc_r <= 1'b0;
      end else begin
         if (hi_agree) hi_osc_r <= hi_sync_r[2];
         if (lo_agree) lo_osc_r <= lo_sync_r[2];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // PLL model: measure the oscillator period in ref_clk cycles and emit eight
   // half-periods per oscillator period. Output rate is bounded by ref_clk/2,
   // so the x4 ratio is exact only while the oscillator is slow enough.

   logic             hi_osc_d_r;
   logic [PER_W-1:0] per_cnt_r;
   logic [PER_W-1:0] per_r;
   logic [PER_W-1:0] ph_cnt_r;
   logic             pll_clk_r;

   wire              hi_rise  = hi_osc_r & ~hi_osc_d_r;
   wire              per_full = &per_cnt_r;
   wire [PER_W-1:0]  half_raw = per_r >> `CS_PLL_HALF_SHIFT;
   wire [PER_W-1:0]  half_eff = (half_raw == '0) ? PER_W'(1) : half_raw;
   wire [PER_W-1:0]  ph_next  = ph_cnt_r + 1'b1;
   wire              ph_wrap  = (ph_next >= half_eff);

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         hi_osc_d_r <= 1'b0;
         per_cnt_r  <= '0;
         per_r      <= '0;
      end else begin
         hi_osc_d_r <= hi_osc_r;
         if (hi_rise) begin
            per_r     <= per_cnt_r;
            per_cnt_r <= PER_W'(1);
         end else if (!per_full) begin
            per_cnt_r <= per_cnt_r + 1'b1;
         end
      end
   end

   // Held low while disabled so the source mux can always leave it
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         ph_cnt_r  <= '0;
         pll_clk_r <= 1'b0;
      end else if (!pll_en_r) begin
         ph_cnt_r  <= '0;
         pll_clk_r <= 1'b0;
      end else if (ph_wrap) begin
         ph_cnt_r  <= '0;
         pll_clk_r <= ~pll_clk_r;
      end else begin
         ph_cnt_r  <= ph_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // High-speed source: oscillator or PLL

   logic hs_clk;
   logic hs_sel_active;

   safe_clk_mux u_hs_mux (
      .ref_clk    (ref_clk),
      .reset      (reset),
      .clk_a      (hi_osc_r),
      .clk_b      (pll_clk_r),
      .sel        (pll_use_bit_r),
      .clk_out    (hs_clk),
      .sel_active (hs_sel_active)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Gear and prescaler

   logic gear_clk;
   logic pre_clk;

   pow2_clk_divider #(
      .CNT_W (DIV_W)
   ) u_gear (
      .ref_clk (ref_clk),
      .reset   (reset),
      .clk_in  (hs_clk),
      .shift   (gear_shift),
      .clk_out (gear_clk)
   );

   // Peripheral clock is the geared clock, or the raw high-speed clock
   wire periph_clk = periph_source_field_r ? hs_clk : gear_clk;

   pow2_clk_divider #(
      .CNT_W (DIV_W)
   ) u_prescale (
      .ref_clk (ref_clk),
      .reset   (reset),
      .clk_in  (periph_clk),
      .shift   (pre_shift),
      .clk_out (pre_clk)
   );

   ////////////////////////////////////////////////////////////////////////////
   // System clock: geared high-speed clock or low-speed clock

   logic sys_clk;
   logic sys_active;

   safe_clk_mux u_sys_mux (
      .ref_clk    (ref_clk),
      .reset      (reset),
      .clk_a      (gear_clk),
      .clk_b      (lo_osc_r),
      .sel        (sysclk_sel_r),
      .clk_out    (sys_clk),
      .sel_active (sys_active)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Read path; data valid only in the cycle after the strobe

   logic [31:0] rd_mux;

   always_comb begin
      rd_mux = 32'h00000000;
      if (hit_pll_sel) begin
         rd_mux[`CS_PLL_USE_BIT] = pll_use_bit_r;
      end else if (hit_sysclk_sel) begin
         rd_mux[`CS_SYSCLK_SEL_BIT]  = sysclk_sel_r;
         rd_mux[`CS_SYSCLK_FLAG_BIT] = sys_active;
      end else if (hit_osc_ctrl) begin
         rd_mux[`CS_PLL_EN_BIT]    = pll_en_r;
         rd_mux[`CS_HI_OSC_EN_BIT] = hi_osc_en_r;
         rd_mux[`CS_LO_OSC_EN_BIT] = lo_osc_en_r;
      end else if (hit_sys_ctrl1) begin
         rd_mux[`CS_GEAR_MSB:`CS_GEAR_LSB]         = gear_divide_field_r;
         rd_mux[`CS_PERIPH_SRC_BIT]                = periph_source_field_r;
         rd_mux[`CS_PRESCALE_MSB:`CS_PRESCALE_LSB] = prescale_divide_field_r;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset)       rdata_r <= 32'h00000000;
      else if (reg_rd) rdata_r <= rd_mux;
      else             rdata_r <= 32'h00000000;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs; after reset every path carries the oscillator level

   assign reg_rdata          = rdata_r;
   assign hi_osc_enable      = hi_osc_en_r;
   assign lo_osc_enable      = lo_osc_en_r;
   assign pll_running        = pll_en_r;
   assign high_speed_clock   = hs_clk;
   assign gear_clock         = gear_clk;
   assign prescaler_clock    = pre_clk;
   assign system_clock       = sys_clk;
   assign sysclk_status_flag = sys_active;

endmodule : pll_and_sysclk_select

// ===== tb/clk_sel_checker.sv
// Port-level assertions for the clock selector.
// Assumes slow oscillator pins, so clock phases last two ref_clk cycles or more.
`timescale 1ns/10ps
`include "clk_sel_regs.svh"
module clk_sel_checker (
   input wire logic                  ref_clk,
   input wire logic                  reset,
   input wire logic [`CS_ADDR_W-1:0] reg_addr,
   input wire logic [31:0]           reg_wdata,
   input wire logic                  reg_wr,
   input wire logic                  reg_rd,
   input wire logic [31:0]           reg_rdata,
   input wire logic                  hi_osc_enable,
   input wire logic                  lo_osc_enable,
   input wire logic                  pll_running,
   input wire logic                  system_clock,
   input wire logic                  sysclk_status_flag
);
   logic pll_use_r;
   logic sel_r;
   wire  pll_wr = reg_wr && reg_addr == `CS_PLL_SEL_OFS;
   wire  sel_wr = reg_wr && reg_addr == `CS_SYSCLK_SEL_OFS;
   wire  pll_on_wr = reg_wr && reg_addr == `CS_OSC_CTRL_OFS && reg_wdata[0];
   wire  known = reg_addr == `CS_PLL_SEL_OFS || reg_addr == `CS_SYSCLK_SEL_OFS ||
                 reg_addr == `CS_OSC_CTRL_OFS || reg_addr == `CS_SYS_CTRL1_OFS;
   ////////////////////////////////////////////////////////////////////////////
   // Shadow of the writable select bits, as software last wrote them
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         pll_use_r <= 1'b0;
         sel_r     <= 1'b0;
      end else begin
         pll_use_r <= pll_wr ? reg_wdata[0] : pll_use_r;
         sel_r     <= sel_wr ? reg_wdata[1] : sel_r;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   sequence start_switch;
      sel_wr && reg_wdata[1] != sel_r && sel_r == sysclk_status_flag;
   endsequence
   sequence old_held;
      $stable(sysclk_status_flag) [*2];
   endsequence
   chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("read data not zero outside a read");
   chk_pll_read: assert property (reg_rd && reg_addr == `CS_PLL_SEL_OFS
      |=> reg_rdata == {31'h0, $past(pll_use_r)}) else $error("pll select read wrong");
   chk_sel_read: assert property (reg_rd && reg_addr == `CS_SYSCLK_SEL_OFS
      |=> reg_rdata == {30'h0, $past(sel_r), $past(sysclk_status_flag)})
      else $error("system select read wrong");
   chk_osc_read: assert property (reg_rd && reg_addr == `CS_OSC_CTRL_OFS |=>
      reg_rdata == {22'h0, $past(lo_osc_enable), $past(hi_osc_enable), 7'h0, $past(pll_running)})
      else $error("oscillator control read wrong");
   chk_unmapped_zero: assert property (reg_rd && !known |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   chk_switch_delay: assert property (start_switch |=> old_held)
      else $error("status changed too soon after select write");
   chk_flag_follows: assert property ($changed(sysclk_status_flag)
      |-> sysclk_status_flag == sel_r) else $error("status moved away from select");
   chk_flag_done: assert property (sel_r != sysclk_status_flag
      |-> ##[1:300] sysclk_status_flag == sel_r) else $error("switch did not complete");
   chk_reset_state: assert property ($past(reset) |-> hi_osc_enable && lo_osc_enable
      && !pll_running && !sysclk_status_flag) else $error("wrong state after reset");
   chk_pll_enable: assert property ($rose(pll_running) |-> $past(pll_on_wr))
      else $error("pll started without enable write");
   // Limitation: holds only while oscillator half periods exceed one cycle
   chk_no_runt: assert property ($changed(system_clock) |=> $stable(system_clock))
      else $error("one-cycle phase on system clock");
endmodule : clk_sel_checker

bind pll_and_sysclk_select clk_sel_checker clk_sel_checker_i (
   .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hi_osc_enable(hi_osc_enable),
   .lo_osc_enable(lo_osc_enable), .pll_running(pll_running), .system_clock(system_clock),
   .sysclk_status_flag(sysclk_status_flag));

// ===== tb/test_pll_and_sysclk_select.sv
// Self-checking bench for the clock selector.
// Assumes slow oscillator levels made on ref_clk so the x4 PLL period is exact.
`timescale 1ns/10ps
`include "clk_sel_regs.svh"
module test_pll_and_sysclk_select;
   localparam int HP = 16;
   localparam int LP = 20;
   localparam logic [7:0] A_PLL = `CS_PLL_SEL_OFS;
   localparam logic [7:0] A_SYS = `CS_SYSCLK_SEL_OFS;
   localparam logic [7:0] A_OSC = `CS_OSC_CTRL_OFS;
   localparam logic [7:0] A_CT1 = `CS_SYS_CTRL1_OFS;
   logic        ref_clk;
   logic        reset;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   logic        hi_osc_in = 1'b0;
   logic        lo_osc_in = 1'b0;
   logic        hi_en;
   logic        lo_en;
   logic        pll_run;
   logic        hs_clk;
   logic        gear_clk;
   logic        pre_clk;
   logic        sys_clk;
   logic        flag;
   int          num_errors;
   int          tests_run;
   int          cyc = 0;
   pll_and_sysclk_select pll_and_sysclk_select_i (
      .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hi_osc_in(hi_osc_in),
      .lo_osc_in(lo_osc_in), .hi_osc_enable(hi_en), .lo_osc_enable(lo_en),
      .pll_running(pll_run), .high_speed_clock(hs_clk), .gear_clock(gear_clk),
      .prescaler_clock(pre_clk), .system_clock(sys_clk), .sysclk_status_flag(flag));
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   // Oscillator levels derived from one counter keep both periods exact
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      hi_osc_in <= (cyc % (2 * HP)) < HP;
      lo_osc_in <= (cyc % (2 * LP)) < LP;
   end
   ////////////////////////////////////////////////////////////////////////////
   task results;
      if (num_errors == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : results
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk(n, e, reg_rdata);
   endtask : rd_chk
   function automatic logic sig(input int k);
      case (k)
         0: return hs_clk;
         1: return gear_clk;
         2: return pre_clk;
         default: return sys_clk;
      endcase
   endfunction : sig
   task rise(input int k);
      int n;
      n = 0;
      // Sample once the outputs launched by the edge have settled
      while (sig(k) !== 1'b0 && n < 3000) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      while (sig(k) !== 1'b1 && n < 3000) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      if (n >= 3000) begin
         chk("clock edge", 32'h1, 32'h0);
         results();
      end
   endtask : rise
   task per_chk(input string n, input int k, input int e);
      int t;
      rise(k);
      rise(k);
      t = cyc;
      rise(k);
      chk(n, e, cyc - t);
   endtask : per_chk
   task wait_flag(input logic v);
      int n;
      n = 0;
      while (flag !== v && n < 500) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      chk("status flag", {31'h0, v}, {31'h0, flag});
      if (n >= 500) results();
   endtask : wait_flag
   task do_reset;
      reset <= 1'b1;
      repeat (20) @(posedge ref_clk);
      reset <= 1'b0;
   endtask : do_reset
   ////////////////////////////////////////////////////////////////////////////
   task t_reset_state;
      rd_chk("pll select", A_PLL, 32'h0);
      rd_chk("system select", A_SYS, 32'h0);
      rd_chk("osc control", A_OSC, 32'h300);
      rd_chk("sys control", A_CT1, 32'h0);
      chk("osc pins", 32'h6, {29'h0, hi_en, lo_en, pll_run});
      for (int k = 0; k < 4; k++) per_chk("clock after reset", k, 2 * HP);
   endtask : t_reset_state
   task t_unused;
      wr(A_PLL, 32'hFFFFFFFE);
      rd_chk("pll spare bits", A_PLL, 32'h0);
      wr(A_PLL, 32'hFFFFFFFF);
      rd_chk("pll use bit", A_PLL, 32'h1);
      wr(A_PLL, 32'h0);
      wr(A_SYS, 32'hFFFFFFFD);
      rd_chk("status read only", A_SYS, 32'h0);
      wr(8'h10, 32'hFFFFFFFF);
      rd_chk("unmapped", 8'h10, 32'h0);
   endtask : t_unused
   task t_dividers;
      for (int g = 0; g < 4; g++) begin
         wr(A_CT1, g);
         per_chk("gear", 1, (2 * HP) << g);
         per_chk("system on gear", 3, (2 * HP) << g);
         per_chk("prescale from gear", 2, (2 * HP) << g);
      end
      // Source bit set with gear /2: prescaler must take the raw high-speed clock
      for (int p = 0; p < 6; p++) begin
         wr(A_CT1, 32'h11 | (p << 8));
         per_chk("prescale", 2, (2 * HP) << p);
      end
      // Codes outside the tables fall back to divide-by-one
      wr(A_CT1, 32'h706);
      per_chk("gear spare code", 1, 2 * HP);
      per_chk("prescale spare code", 2, 2 * HP);
      wr(A_CT1, 32'h0);
   endtask : t_dividers
   task t_switch;
      wr(A_OSC, 32'h300);
      wr(A_SYS, 32'h2);
      wait_flag(1'b1);
      rd_chk("switched low", A_SYS, 32'h3);
      per_chk("system low", 3, 2 * LP);
      wr(A_SYS, 32'h0);
      wait_flag(1'b0);
      rd_chk("switched high", A_SYS, 32'h0);
      per_chk("system high", 3, 2 * HP);
      wr(A_OSC, 32'h100);
      #1 chk("osc enables", 32'h4, {29'h0, hi_en, lo_en, pll_run});
   endtask : t_switch
   task t_pll;
      wr(A_OSC, 32'h301);
      #1 chk("pll on", 32'h1, {31'h0, pll_run});
      // Lock allowance before the multiplied clock is taken
      repeat (200) @(posedge ref_clk);
      wr(A_PLL, 32'h1);
      per_chk("pll clock", 0, 2 * HP / 4);
      per_chk("system on pll", 3, 2 * HP / 4);
      do_reset();
      rd_chk("pll select reset", A_PLL, 32'h0);
      chk("pll off", 32'h0, {31'h0, pll_run});
      per_chk("hs after reset", 0, 2 * HP);
   endtask : t_pll
   initial begin
      reset = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      num_errors = 0;
      tests_run = 0;
      do_reset();
      t_reset_state();
      t_unused();
      t_dividers();
      t_switch();
      t_pll();
      results();
   end
endmodule : test_pll_and_sysclk_select
